// ---- rtl/cprd_cfg.svh ----
/*
 * Constants for the core clock ratio strap decoder: strap codes, multiplier
 * encodings, Avalon register offsets and field positions.
 * Assumes inclusion by bare name from the rtl/ folder.
 */
`ifndef CPRD_CFG_SVH
`define CPRD_CFG_SVH

// Strap codes, bits [5:0], bit 5 the leftmost strap digit
`define CPRD_CODE_2X      6'h10
`define CPRD_CODE_3X      6'h20
`define CPRD_CODE_4X      6'h28
`define CPRD_CODE_5X      6'h2C
`define CPRD_CODE_5X5     6'h24
`define CPRD_CODE_6X      6'h34
`define CPRD_CODE_6X5     6'h14
`define CPRD_CODE_7X      6'h08
`define CPRD_CODE_7X5     6'h04
`define CPRD_CODE_8X      6'h30
`define CPRD_CODE_8X5     6'h18
`define CPRD_CODE_9X      6'h1E
`define CPRD_CODE_9X5     6'h1C
`define CPRD_CODE_10X     6'h2A
`define CPRD_CODE_10X5    6'h22
`define CPRD_CODE_11X     6'h26
`define CPRD_CODE_11X5    6'h00
`define CPRD_CODE_12X     6'h2E
`define CPRD_CODE_12X5    6'h3E
`define CPRD_CODE_13X     6'h16
`define CPRD_CODE_13X5    6'h38
`define CPRD_CODE_14X     6'h32
`define CPRD_CODE_15X     6'h06
`define CPRD_CODE_16X     6'h36
`define CPRD_CODE_17X     6'h02
`define CPRD_CODE_18X     6'h0A
`define CPRD_CODE_20X     6'h0E
`define CPRD_CODE_21X     6'h12
`define CPRD_CODE_24X     6'h1A
`define CPRD_CODE_28X     6'h3A
`define CPRD_CODE_BYPASS  6'h0C
`define CPRD_CODE_OFF     6'h3C

// Multiplier held in half steps (value = 2 * ratio)
`define CPRD_HALF_W       7
`define CPRD_VCO_MULT     4'h1
`define CPRD_LOW_RATIO    7'h0A

// Avalon word offsets (byte address = 4 * index)
`define CPRD_REG_STATUS   2'h0
`define CPRD_REG_CTRL     2'h1
`define CPRD_REG_RATIO    2'h2

// Status fields
`define CPRD_ST_CODE_LSB  0
`define CPRD_ST_MODE_LSB  8
`define CPRD_ST_RSVD_BIT  10
`define CPRD_ST_T5_BIT    11
`define CPRD_ST_LOW_BIT   12
`define CPRD_ST_CHG_BIT   13

// Control fields
`define CPRD_CT_DFS_LSB   0
`define CPRD_CT_CHG_BIT   4

// Ratio register fields
`define CPRD_RT_STRAP_LSB 0
`define CPRD_RT_EFF_LSB   8
`define CPRD_RT_QUAL_BIT  16
`define CPRD_RT_BUSD_BIT  17

`endif

// ---- rtl/cprd_pkg.sv ----
/*
 * Types for the core clock ratio strap decoder.
 * Assumes cprd_cfg.svh is compiled alongside.
 */
package cprd_pkg;

    typedef enum logic [1:0]
    {
        CPRD_MODE_PLL    = 2'b00,
        CPRD_MODE_BYPASS = 2'b01,
        CPRD_MODE_OFF    = 2'b10,
        CPRD_MODE_RSVD   = 2'b11
    } cprd_mode_t;

    typedef enum logic [1:0]
    {
        CPRD_DFS_NONE    = 2'b00,
        CPRD_DFS_HALF    = 2'b01,
        CPRD_DFS_QUARTER = 2'b10,
        CPRD_DFS_RSVD    = 2'b11
    } cprd_dfs_t;

endpackage

// ---- rtl/cprd_strap_sync.sv ----
/*
 * Three-stage synchroniser for the six strap pins; a change is taken once
 * the second and third stages agree.
 * Assumes strap pins are asynchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

module cprd_strap_sync
    import cprd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [5:0] strap_pin,
    output var  logic [5:0] strap_stable
);

    logic [5:0] stage1;
    logic [5:0] stage2;
    logic [5:0] stage3;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1 <= 6'h00;
            stage2 <= 6'h00;
            stage3 <= 6'h00;
        end
        else
        begin
            stage1 <= strap_pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Bits whose two late stages disagree keep the old value
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            strap_stable <= 6'h00;
        else
            strap_stable <= (stage2 & stage3) | (strap_stable & (stage2 ^ stage3));
    end

endmodule

`default_nettype wire

// ---- rtl/cprd_core.sv ----
/*
 * Core clock ratio strap decoder: decodes the six strap pins into the
 * bus-to-core multiplier, PLL bypass and PLL off modes, applies dynamic
 * frequency switching and flags low ratios; Avalon-MM slave for status.
 * Assumes straps are static pins, one clock clk_sys at 20 MHz.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cprd_cfg.svh"

module cprd_core
    import cprd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [5:0]  strap_pin,
    input  wire logic        bypass_bus_qualifier,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic      [1:0]  avs_response,
    output logic             avs_waitrequest,
    output logic             pll_enable,
    output logic             core_clock_gate,
    output logic             core_from_reference,
    output logic      [6:0]  core_mult_half,
    output logic      [1:0]  dfs_shift,
    output logic             bus_half_rate_en,
    output logic             address_acknowledge_delay
);

    logic [5:0]  strap;
    logic [5:0]  strap_q;
    logic [6:0]  strap_half;
    cprd_mode_t  mode;
    cprd_dfs_t   dynamic_freq_switching;
    logic        strap_changed;
    logic        qual_q;
    logic        busy;
    logic        was_access;

    cprd_strap_sync u_sync
    (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .strap_pin    (strap_pin),
        .strap_stable (strap)
    );

    // Twice the ratio, so half steps stay integers; zero means not a ratio
    function automatic logic [6:0] ratio_half(input logic [5:0] code);
        case (code)
            `CPRD_CODE_2X:   ratio_half = 7'h04;
            `CPRD_CODE_3X:   ratio_half = 7'h06;
            `CPRD_CODE_4X:   ratio_half = 7'h08;
            `CPRD_CODE_5X:   ratio_half = 7'h0A;
            `CPRD_CODE_5X5:  ratio_half = 7'h0B;
            `CPRD_CODE_6X:   ratio_half = 7'h0C;
            `CPRD_CODE_6X5:  ratio_half = 7'h0D;
            `CPRD_CODE_7X:   ratio_half = 7'h0E;
            `CPRD_CODE_7X5:  ratio_half = 7'h0F;
            `CPRD_CODE_8X:   ratio_half = 7'h10;
            `CPRD_CODE_8X5:  ratio_half = 7'h11;
            `CPRD_CODE_9X:   ratio_half = 7'h12;
            `CPRD_CODE_9X5:  ratio_half = 7'h13;
            `CPRD_CODE_10X:  ratio_half = 7'h14;
            `CPRD_CODE_10X5: ratio_half = 7'h15;
            `CPRD_CODE_11X:  ratio_half = 7'h16;
            `CPRD_CODE_11X5: ratio_half = 7'h17;
            `CPRD_CODE_12X:  ratio_half = 7'h18;
            `CPRD_CODE_12X5: ratio_half = 7'h19;
            `CPRD_CODE_13X:  ratio_half = 7'h1A;
            `CPRD_CODE_13X5: ratio_half = 7'h1B;
            `CPRD_CODE_14X:  ratio_half = 7'h1C;
            `CPRD_CODE_15X:  ratio_half = 7'h1E;
            `CPRD_CODE_16X:  ratio_half = 7'h20;
            `CPRD_CODE_17X:  ratio_half = 7'h22;
            `CPRD_CODE_18X:  ratio_half = 7'h24;
            `CPRD_CODE_20X:  ratio_half = 7'h28;
            `CPRD_CODE_21X:  ratio_half = 7'h2A;
            `CPRD_CODE_24X:  ratio_half = 7'h30;
            `CPRD_CODE_28X:  ratio_half = 7'h38;
            default:         ratio_half = 7'h00;
        endcase
    endfunction

    assign strap_half = ratio_half(strap);

    // Decoded state registered once; outputs follow from these
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            mode <= CPRD_MODE_OFF;
        else if (strap == `CPRD_CODE_BYPASS)
            mode <= CPRD_MODE_BYPASS;
        else if (strap == `CPRD_CODE_OFF)
            mode <= CPRD_MODE_OFF;
        else if (strap_half != 7'h00)
            mode <= CPRD_MODE_PLL;
        else
            mode <= CPRD_MODE_RSVD;
    end

    // Reserved codes stop the core, as PLL off does
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pll_enable          <= 1'b0;
            core_clock_gate     <= 1'b0;
            core_from_reference <= 1'b0;
        end
        else
        begin
            case (mode)
                CPRD_MODE_PLL:
                begin
                    pll_enable          <= 1'b1;
                    core_clock_gate     <= 1'b1;
                    core_from_reference <= 1'b0;
                end
                CPRD_MODE_BYPASS:
                begin
                    pll_enable          <= 1'b0;
                    core_clock_gate     <= 1'b1;
                    core_from_reference <= 1'b1;
                end
                default:
                begin
                    pll_enable          <= 1'b0;
                    core_clock_gate     <= 1'b0;
                    core_from_reference <= 1'b0;
                end
            endcase
        end
    end

    // Multiplier: strap ratio unshifted; switching mode goes out as dfs_shift
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            core_mult_half <= 7'h00;
            dfs_shift      <= 2'h0;
        end
        else if (mode != CPRD_MODE_PLL)
        begin
            core_mult_half <= 7'h00;
            dfs_shift      <= 2'h0;
        end
        else
        begin
            case (dynamic_freq_switching)
                CPRD_DFS_HALF:    dfs_shift <= 2'h1;
                CPRD_DFS_QUARTER: dfs_shift <= 2'h2;
                default:          dfs_shift <= 2'h0;
            endcase
            core_mult_half <= strap_half;
        end
    end

    // Low-ratio hint for the bus controller's acknowledge timing
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            address_acknowledge_delay <= 1'b0;
        else
            address_acknowledge_delay <= (mode == CPRD_MODE_PLL)
                && (strap_half < `CPRD_LOW_RATIO);
    end

    // Board times the qualifier to the reference edge, so one capture flop
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            qual_q <= 1'b0;
        else
            qual_q <= bypass_bus_qualifier;
    end

    // Bus half rate in bypass, qualified by the external signal
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            bus_half_rate_en <= 1'b0;
        else
            bus_half_rate_en <= (mode == CPRD_MODE_BYPASS) && qual_q;
    end

    // Sticky strap-change flag; a new change wins over a clear
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            strap_q <= 6'h00;
        else
            strap_q <= strap;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            strap_changed <= 1'b0;
        else if (strap != strap_q)
            strap_changed <= 1'b1;
        else if (avs_write && !avs_waitrequest && avs_address == `CPRD_REG_CTRL
                 && avs_writedata[`CPRD_CT_CHG_BIT])
            strap_changed <= 1'b0;
    end

    // Avalon slave: one wait state, then a one-cycle answer
    assign busy = (avs_read || avs_write) && !was_access;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            was_access      <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            was_access      <= busy;
            avs_waitrequest <= !busy;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            dynamic_freq_switching <= CPRD_DFS_NONE;
        else if (avs_write && !avs_waitrequest && avs_address == `CPRD_REG_CTRL)
            dynamic_freq_switching <= cprd_dfs_t'(avs_writedata[1:0]);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end
        else if (busy && avs_read)
        begin
            avs_response <= 2'h0;
            case (avs_address)
                `CPRD_REG_STATUS:
                    avs_readdata <= {18'h0, strap_changed,
                        address_acknowledge_delay, strap[5], mode == CPRD_MODE_RSVD,
                        mode, 2'h0, strap};
                `CPRD_REG_CTRL:
                    avs_readdata <= {30'h0, dynamic_freq_switching};
                `CPRD_REG_RATIO:
                    avs_readdata <= {14'h0, bus_half_rate_en, qual_q, 1'b0,
                        core_mult_half >> dfs_shift, 1'b0, strap_half};
                default:
                begin
                    avs_readdata <= 32'h0000_0000;
                    avs_response <= 2'h2;
                end
            endcase
        end
        else if (busy)
        begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= (avs_address > `CPRD_REG_RATIO) ? 2'h2 : 2'h0;
        end
    end

    AST_OFF_NO_CLOCK: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode == CPRD_MODE_OFF |=> !core_clock_gate && !pll_enable)
        else $error("core clocked in PLL off mode");
    AST_BYPASS_REF: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode == CPRD_MODE_BYPASS |=> core_from_reference && !pll_enable)
        else $error("bypass does not select reference clock");
    AST_PLL_ON: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode == CPRD_MODE_PLL |=> pll_enable && core_clock_gate)
        else $error("PLL not enabled for ratio code");
    AST_RATIO_28: assert property (@(posedge clk_sys) disable iff (!rstn)
        strap == `CPRD_CODE_28X [*2] |=> core_mult_half == 7'h38)
        else $error("28x code wrong multiplier");
    AST_RATIO_11X5: assert property (@(posedge clk_sys) disable iff (!rstn)
        strap == `CPRD_CODE_11X5 [*2] |=> core_mult_half == 7'h17)
        else $error("11.5x code wrong multiplier");
    AST_RATIO_2: assert property (@(posedge clk_sys) disable iff (!rstn)
        strap == `CPRD_CODE_2X [*2] |=> core_mult_half == 7'h04)
        else $error("2x code wrong multiplier");
    AST_DFS_NONE: assert property (@(posedge clk_sys) disable iff (!rstn)
        dynamic_freq_switching == CPRD_DFS_NONE [*2] |=> dfs_shift == 2'h0)
        else $error("shift applied with switching off");
    AST_DFS_QTR: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode == CPRD_MODE_PLL && dynamic_freq_switching == CPRD_DFS_QUARTER
        |=> dfs_shift == 2'h2)
        else $error("quarter mode not applied");
    AST_LOW_ACK: assert property (@(posedge clk_sys) disable iff (!rstn)
        strap == `CPRD_CODE_4X [*2] |=> address_acknowledge_delay)
        else $error("low ratio not flagged");
    AST_BUS_HALF: assert property (@(posedge clk_sys) disable iff (!rstn)
        bus_half_rate_en |-> $past(mode) == CPRD_MODE_BYPASS)
        else $error("half rate bus outside bypass");

    COV_BYPASS: cover property (@(posedge clk_sys) mode == CPRD_MODE_BYPASS);
    COV_OFF: cover property (@(posedge clk_sys) mode == CPRD_MODE_OFF ##1 core_clock_gate == 1'b0);
    COV_HALF: cover property (@(posedge clk_sys) dfs_shift == 2'h1);
    COV_READ: cover property (@(posedge clk_sys) avs_read && !avs_waitrequest);

endmodule

`default_nettype wire

// ---- tb/cprd_board_model.sv ----
/*
 * Board side of the strap decoder: strap resistors and the half-rate
 * bypass qualifier from the clock generator.
 * Assumes the bench picks the strap code and starts the qualifier.
 */
`timescale 1ns/100ps
`default_nettype none

module cprd_board_model
    import cprd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [5:0] strap_code,
    input  wire logic       qual_run,
    output var  logic [5:0] strap_pin,
    output var  logic       bypass_bus_qualifier
);
    initial
    begin
        strap_pin = 6'h3C;
        bypass_bus_qualifier = 1'b0;
    end

    // Only listed codes are ever requested; held firm between requests
    always @(posedge clk_sys)
    begin
        strap_pin <= strap_code;
    end

    // Launched on the rising edge, so it is stable across the next sample
    always @(posedge clk_sys)
    begin
        bypass_bus_qualifier <= qual_run ? ~bypass_bus_qualifier : 1'b0;
    end
endmodule

`default_nettype wire

// ---- tb/tb_core_pll_ratio_strap_decode.sv ----
/*
 * Self-checking bench for the strap decoder: walks the ratio table,
 * bypass, off, frequency switching and the Avalon registers.
 * Assumes cprd_core and the board model; 20 MHz clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cprd_cfg.svh"

module tb_core_pll_ratio_strap_decode
    import cprd_pkg::*;
;
    localparam logic [5:0] CODES [30] = '{6'h10, 6'h20, 6'h28, 6'h2C, 6'h24, 6'h34,
        6'h14, 6'h08, 6'h04, 6'h30, 6'h18, 6'h1E, 6'h1C, 6'h2A, 6'h22, 6'h26, 6'h00,
        6'h2E, 6'h3E, 6'h16, 6'h38, 6'h32, 6'h06, 6'h36, 6'h02, 6'h0A, 6'h0E, 6'h12,
        6'h1A, 6'h3A};
    // Ratio held in half steps
    localparam logic [6:0] HALVES [30] = '{7'h04, 7'h06, 7'h08, 7'h0A, 7'h0B, 7'h0C,
        7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
        7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1E, 7'h20, 7'h22, 7'h24, 7'h28, 7'h2A,
        7'h30, 7'h38};
    localparam logic [3:0] A_ST = {2'h0, `CPRD_REG_STATUS};
    localparam logic [3:0] A_CT = {2'h0, `CPRD_REG_CTRL};
    localparam logic [3:0] A_RT = {2'h0, `CPRD_REG_RATIO};

    logic        clk_sys;
    logic        rstn;
    logic [5:0]  strap_code;
    logic        qual_run;
    logic [5:0]  strap_pin;
    logic        bypass_bus_qualifier;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic [1:0]  avs_response;
    logic        avs_waitrequest;
    logic        pll_enable;
    logic        core_clock_gate;
    logic        core_from_reference;
    logic [6:0]  core_mult_half;
    logic [1:0]  dfs_shift;
    logic        bus_half_rate_en;
    logic        address_acknowledge_delay;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic [1:0]  eshift;
    int          err_total;
    int          check_count;
    int          hits;

    cprd_board_model board
    (
        .clk_sys              (clk_sys),
        .strap_code           (strap_code),
        .qual_run             (qual_run),
        .strap_pin            (strap_pin),
        .bypass_bus_qualifier (bypass_bus_qualifier)
    );

    cprd_core uut
    (
        .clk_sys                   (clk_sys),
        .rstn                      (rstn),
        .strap_pin                 (strap_pin),
        .bypass_bus_qualifier      (bypass_bus_qualifier),
        .avs_address               (avs_address),
        .avs_read                  (avs_read),
        .avs_write                 (avs_write),
        .avs_writedata             (avs_writedata),
        .avs_readdata              (avs_readdata),
        .avs_response              (avs_response),
        .avs_waitrequest           (avs_waitrequest),
        .pll_enable                (pll_enable),
        .core_clock_gate           (core_clock_gate),
        .core_from_reference       (core_from_reference),
        .core_mult_half            (core_mult_half),
        .dfs_shift                 (dfs_shift),
        .bus_half_rate_en          (bus_half_rate_en),
        .address_acknowledge_delay (address_acknowledge_delay)
    );

    task automatic close_out();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [6:0] got, input logic [6:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= wd;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge clk_sys);
        // Only the watchdog ends a stuck wait
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Strap path is synchroniser plus decode, well inside ten edges
    task automatic set_strap(input logic [5:0] c);
        strap_code <= c;
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic count_half();
        hits = 0;
        repeat (8)
        begin
            @(posedge clk_sys);
            if (bus_half_rate_en === 1'b1)
                hits++;
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        #200000;
        err_total++;
        close_out();
    end

    initial
    begin
        err_total = 0;
        check_count = 0;
        rstn = 1'b0;
        strap_code = 6'h3C;
        qual_run = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (10) @(posedge clk_sys);
        chk_out({5'h0, avs_waitrequest, pll_enable}, 7'h02);
        rstn <= 1'b1;
        for (int i = 0; i < 30; i++)
        begin
            set_strap(CODES[i]);
            chk_out(core_mult_half, HALVES[i]);
            chk_out({3'h0, pll_enable, core_clock_gate, core_from_reference,
                     bus_half_rate_en}, 7'h0C);
            chk_out({6'h0, address_acknowledge_delay}, {6'h0, HALVES[i] < 7'h0A});
            bus_xfer(1'b0, A_RT, 32'h0);
            chk32(rd & 32'h7F7F, {17'h0, HALVES[i], 1'b0, HALVES[i]});
            bus_xfer(1'b0, A_ST, 32'h0);
            chk32(rd & 32'h1FFF, {19'h0, HALVES[i] < 7'h0A, CODES[i][5], 5'h0,
                  CODES[i]});
        end
        bus_xfer(1'b0, A_ST, 32'h0);
        chk32(rd & 32'h2000, 32'h2000);
        bus_xfer(1'b1, A_CT, 32'h10);
        bus_xfer(1'b0, A_ST, 32'h0);
        chk32(rd & 32'h2000, 32'h0);
        for (int d = 0; d < 4; d++)
        begin
            eshift = (d == 3) ? 2'h0 : d[1:0];
            bus_xfer(1'b1, A_CT, d);
            bus_xfer(1'b0, A_RT, 32'h0);
            chk32(rd & 32'h7F7F, {17'h0, 7'h38 >> eshift, 8'h38});
            chk_out({5'h0, dfs_shift}, {5'h0, eshift});
        end
        set_strap(6'h0C);
        chk_out({4'h0, pll_enable, core_clock_gate, core_from_reference}, 7'h03);
        chk_out(core_mult_half, 7'h00);
        count_half();
        chk_out(hits[6:0], 7'h04);
        bus_xfer(1'b0, A_ST, 32'h0);
        chk32(rd & 32'h0300, 32'h0100);
        qual_run <= 1'b0;
        repeat (4) @(posedge clk_sys);
        count_half();
        chk_out(hits[6:0], 7'h00);
        qual_run <= 1'b1;
        set_strap(6'h3C);
        chk_out({4'h0, pll_enable, core_clock_gate, core_from_reference}, 7'h00);
        count_half();
        chk_out(hits[6:0], 7'h00);
        bus_xfer(1'b0, A_ST, 32'h0);
        chk32(rd & 32'h0300, 32'h0200);
        bus_xfer(1'b1, 4'h7, 32'h2);
        chk_out({5'h0, rsp}, 7'h02);
        bus_xfer(1'b0, 4'h3, 32'h0);
        chk32(rd, 32'h0);
        chk_out({5'h0, rsp}, 7'h02);
        bus_xfer(1'b0, A_CT, 32'h0);
        chk32(rd & 32'h3, 32'h3);
        close_out();
    end
endmodule

`default_nettype wire
